// [tseg_top.sv]
// Status flags and software event generation of a one-channel timer.
// Assumes an Avalon-MM master with byte addresses and synchronous pulses
// on trigger_reinit_i and capture_event_i.
//
// Function
// R1 - update event sets update flag, write 0 clears
// R2 - overflow or underflow updates unless updates disabled
// R3 - software update sets flag when source select 0
// R4 - trigger reinit updates when source select 0
// R5 - output mode: counter equals compare sets channel flag
// R6 - input mode: capture sets channel flag
// R7 - channel flag cleared by write 0 or value read
// R8 - capture with channel flag set raises repeat flag
// R9 - update generate bit reinitialises counter, self clears
// R10 - update event clears prescaler counter, keeps factor
// R11 - software update: down loads reload, else zero
// R12 - channel generate bit forces channel event, self clears
// R13 - forced output event sets flag, irq, dma
// R14 - forced input event captures counter, sets flag
// R15 - forced capture with flag set raises repeat flag
// R16 - source select 1: only wraps request irq/dma
// R17 - reserved bits read zero, writes ignored
`timescale 1ns/1ps
module tseg_top (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Timer events
  input  wire logic        trigger_reinit_i,
  input  wire logic        capture_event_i,
  // Requests
  output logic             update_irq_o,
  output logic             update_dma_o,
  output logic             channel_irq_o,
  output logic             channel_dma_o
);

  tseg_cnt_if cif ();

  logic [15:0] control_r;
  logic [15:0] enables_r;
  logic [1:0]  chmode_r;
  logic [15:0] prescale_r;
  logic [15:0] reload_r;
  logic [15:0] channel_value_r;
  logic        update_flag_r;
  logic        channel_one_flag_r;
  logic        repeat_capture_flag_r;
  logic        update_generate_r;
  logic        channel_one_generate_r;
  logic        match_r;
  logic        ack_r;

  logic                 access;
  logic                 wr_acc;
  logic                 rd_acc;
  tseg_pkg::tseg_sel_t  sel;
  logic [15:0]          wmask;
  logic [15:0]          wval;
  logic                 output_mode;
  logic                 wrap_upd;
  logic                 soft_upd;
  logic                 any_upd;
  logic                 flag_upd;
  logic                 capture;
  logic                 compare_hit;
  logic [15:0]          rd_nxt;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic tseg_pkg::tseg_sel_t decode(input logic [7:0] addr);
    unique case ({addr[7:2], 2'b00})
      tseg_pkg::OFF_CONTROL:  decode = tseg_pkg::SEL_CONTROL;
      tseg_pkg::OFF_ENABLES:  decode = tseg_pkg::SEL_ENABLES;
      tseg_pkg::OFF_STATUS:   decode = tseg_pkg::SEL_STATUS;
      tseg_pkg::OFF_EVENT:    decode = tseg_pkg::SEL_EVENT;
      tseg_pkg::OFF_CHMODE:   decode = tseg_pkg::SEL_CHMODE;
      tseg_pkg::OFF_COUNTER:  decode = tseg_pkg::SEL_COUNTER;
      tseg_pkg::OFF_PRESCALE: decode = tseg_pkg::SEL_PRESCALE;
      tseg_pkg::OFF_RELOAD:   decode = tseg_pkg::SEL_RELOAD;
      tseg_pkg::OFF_CHANNEL:  decode = tseg_pkg::SEL_CHANNEL;
      default:                decode = tseg_pkg::SEL_NONE;
    endcase
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] m, input logic [15:0] keep);
    merge = ((old & ~m) | (nw & m)) & keep;
  endfunction

  // ************************************************************
  // Bus access
  // ************************************************************
  // Request taken while waitrequest is high; answer one cycle later
  assign access = (avs_read || avs_write) && avs_waitrequest;
  assign wr_acc = access && avs_write;
  assign rd_acc = access && avs_read;
  assign sel    = decode(avs_address);
  assign wmask  = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wval   = avs_writedata[15:0];

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !access;
    end
  end

  always_comb begin
    rd_nxt = 16'h0000;
    unique case (sel)
      tseg_pkg::SEL_CONTROL:  rd_nxt = control_r;
      tseg_pkg::SEL_ENABLES:  rd_nxt = enables_r;
      tseg_pkg::SEL_STATUS:   rd_nxt = 16'h0000
                                     | (16'(update_flag_r) << tseg_pkg::ST_UPDATE)
                                     | (16'(channel_one_flag_r) << tseg_pkg::ST_CH1)
                                     | (16'(repeat_capture_flag_r) << tseg_pkg::ST_REPEAT); // R17
      tseg_pkg::SEL_CHMODE:   rd_nxt = {14'h0000, chmode_r};
      tseg_pkg::SEL_COUNTER:  rd_nxt = cif.count;
      tseg_pkg::SEL_PRESCALE: rd_nxt = prescale_r;
      tseg_pkg::SEL_RELOAD:   rd_nxt = reload_r;
      tseg_pkg::SEL_CHANNEL:  rd_nxt = channel_value_r;
      tseg_pkg::SEL_EVENT,
      tseg_pkg::SEL_NONE:     rd_nxt = 16'h0000; // R17
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_acc) begin
      avs_readdata <= {16'h0000, rd_nxt};
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      control_r  <= tseg_pkg::REG_RESET;
      enables_r  <= tseg_pkg::REG_RESET;
      chmode_r   <= tseg_pkg::CH_OUTPUT;
      prescale_r <= tseg_pkg::REG_RESET;
      reload_r   <= tseg_pkg::REG_RESET;
    end else if (wr_acc) begin
      unique case (sel)
        tseg_pkg::SEL_CONTROL:
          control_r <= merge(control_r, wval, wmask, tseg_pkg::CONTROL_MASK);
        tseg_pkg::SEL_ENABLES:
          enables_r <= merge(enables_r, wval, wmask, tseg_pkg::ENABLES_MASK);
        tseg_pkg::SEL_CHMODE:
          chmode_r <= 2'(merge({14'h0000, chmode_r}, wval, wmask, tseg_pkg::CHMODE_MASK));
        tseg_pkg::SEL_PRESCALE:
          prescale_r <= merge(prescale_r, wval, wmask, 16'hffff);
        tseg_pkg::SEL_RELOAD:
          reload_r <= merge(reload_r, wval, wmask, 16'hffff);
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Event generation
  // ************************************************************
  // Generate bits are held one cycle and then dropped by hardware
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      update_generate_r      <= 1'b0;
      channel_one_generate_r <= 1'b0;
    end else begin
      update_generate_r      <= wr_acc && sel == tseg_pkg::SEL_EVENT && avs_byteenable[0]
                                && wval[tseg_pkg::EV_UPDATE];  // R9
      channel_one_generate_r <= wr_acc && sel == tseg_pkg::SEL_EVENT && avs_byteenable[0]
                                && wval[tseg_pkg::EV_CH1];     // R12
    end
  end

  assign output_mode = (chmode_r == tseg_pkg::CH_OUTPUT);
  assign wrap_upd    = cif.wrap && !control_r[tseg_pkg::CTL_UPD_DIS];             // R2
  assign soft_upd    = (update_generate_r || trigger_reinit_i)
                       && !control_r[tseg_pkg::CTL_UPD_DIS];
  assign any_upd     = wrap_upd || soft_upd;
  // Source select 1 keeps software and trigger updates off the flag
  assign flag_upd    = wrap_upd || (soft_upd && !control_r[tseg_pkg::CTL_UPD_SRC]); // R3 R4 R16
  assign capture     = !output_mode && (capture_event_i || channel_one_generate_r); // R6 R14
  assign compare_hit = output_mode && (cif.count == channel_value_r) && !match_r;

  // ************************************************************
  // Counter core link
  // ************************************************************
  assign cif.count_en  = control_r[tseg_pkg::CTL_COUNT_EN];
  assign cif.down      = control_r[tseg_pkg::CTL_DOWN];
  assign cif.center    = control_r[tseg_pkg::CTL_CENTER];
  assign cif.prescale  = prescale_r;
  assign cif.reload    = reload_r;
  // Reinit happens even with updates disabled: the counter must restart
  assign cif.reinit    = update_generate_r || trigger_reinit_i; // R9 R11
  assign cif.psc_clear = any_upd;                               // R10
  assign cif.cnt_write = wr_acc && sel == tseg_pkg::SEL_COUNTER;
  assign cif.cnt_wdata = merge(cif.count, wval, wmask, 16'hffff);

  tseg_counter u_counter (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .cif     (cif)
  );

  // ************************************************************
  // Compare match and capture value
  // ************************************************************
  // Flag only on the first cycle of a match, so a stalled counter
  // does not keep re-setting a flag that software just cleared
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      // Counter and compare both reset to zero, so start matched: no false edge
      match_r <= 1'b1;
    end else begin
      match_r <= output_mode && (cif.count == channel_value_r);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      channel_value_r <= tseg_pkg::REG_RESET;
    end else if (capture) begin
      channel_value_r <= cif.count; // R14
    end else if (wr_acc && sel == tseg_pkg::SEL_CHANNEL && output_mode) begin
      channel_value_r <= merge(channel_value_r, wval, wmask, 16'hffff);
    end
  end

  // ************************************************************
  // Status flags
  // ************************************************************
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      update_flag_r <= 1'b0;
    end else if (flag_upd) begin
      update_flag_r <= 1'b1; // R1
    end else if (wr_acc && sel == tseg_pkg::SEL_STATUS && avs_byteenable[0]
                 && !wval[tseg_pkg::ST_UPDATE]) begin
      update_flag_r <= 1'b0; // R1
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      channel_one_flag_r <= 1'b0;
    end else if (compare_hit || capture
                 || (output_mode && channel_one_generate_r)) begin
      channel_one_flag_r <= 1'b1; // R5 R6 R13 R14
    end else if ((wr_acc && sel == tseg_pkg::SEL_STATUS && avs_byteenable[0]
                  && !wval[tseg_pkg::ST_CH1])
                 || (rd_acc && sel == tseg_pkg::SEL_CHANNEL)) begin
      channel_one_flag_r <= 1'b0; // R7
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      repeat_capture_flag_r <= 1'b0;
    end else if (capture && channel_one_flag_r) begin
      repeat_capture_flag_r <= 1'b1; // R8 R15
    end else if (wr_acc && sel == tseg_pkg::SEL_STATUS && avs_byteenable[1]
                 && !wval[tseg_pkg::ST_REPEAT]) begin
      repeat_capture_flag_r <= 1'b0; // R8
    end
  end

  // ************************************************************
  // Request outputs
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      update_irq_o  <= 1'b0;
      update_dma_o  <= 1'b0;
      channel_irq_o <= 1'b0;
      channel_dma_o <= 1'b0;
    end else begin
      update_irq_o  <= update_flag_r && enables_r[tseg_pkg::EN_UPD_IRQ];      // R16
      update_dma_o  <= flag_upd && enables_r[tseg_pkg::EN_UPD_DMA];           // R16
      channel_irq_o <= channel_one_flag_r && enables_r[tseg_pkg::EN_CH1_IRQ]; // R13
      channel_dma_o <= (compare_hit || capture || channel_one_generate_r)
                       && enables_r[tseg_pkg::EN_CH1_DMA];                     // R13 R14
    end
  end

endmodule // tseg_top

// [tseg_pkg.sv]
// Constants for the timer status and event generation block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and 16-bit registers.
package tseg_pkg;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_ENABLES   = 8'h0c;
  localparam logic [7:0] OFF_STATUS    = 8'h10;
  localparam logic [7:0] OFF_EVENT     = 8'h14;
  localparam logic [7:0] OFF_CHMODE    = 8'h18;
  localparam logic [7:0] OFF_COUNTER   = 8'h24;
  localparam logic [7:0] OFF_PRESCALE  = 8'h28;
  localparam logic [7:0] OFF_RELOAD    = 8'h2c;
  localparam logic [7:0] OFF_CHANNEL   = 8'h34;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTL_COUNT_EN   = 0;
  localparam int CTL_UPD_DIS    = 1;
  localparam int CTL_UPD_SRC    = 2;
  localparam int CTL_DOWN       = 4;
  localparam int CTL_CENTER     = 5;
  localparam int EN_UPD_IRQ     = 0;
  localparam int EN_CH1_IRQ     = 1;
  localparam int EN_UPD_DMA     = 8;
  localparam int EN_CH1_DMA     = 9;
  localparam int ST_UPDATE      = 0;
  localparam int ST_CH1         = 1;
  localparam int ST_REPEAT      = 9;
  localparam int EV_UPDATE      = 0;
  localparam int EV_CH1         = 1;

  // ************************************************************
  // Writable masks and reset values
  // ************************************************************
  localparam logic [15:0] CONTROL_MASK = 16'h0037;
  localparam logic [15:0] ENABLES_MASK = 16'h0303;
  localparam logic [15:0] CHMODE_MASK  = 16'h0003;
  localparam logic [15:0] REG_RESET    = 16'h0000;
  localparam logic [1:0]  CH_OUTPUT    = 2'h0;

  // ************************************************************
  // Register select
  // ************************************************************
  typedef enum logic [3:0] {
    SEL_NONE, SEL_CONTROL, SEL_ENABLES, SEL_STATUS, SEL_EVENT,
    SEL_CHMODE, SEL_COUNTER, SEL_PRESCALE, SEL_RELOAD, SEL_CHANNEL
  } tseg_sel_t;

endpackage

// [tseg_cnt_if.sv]
// Signals between the status logic and the counter core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface tseg_cnt_if;
  logic        count_en;
  logic        down;
  logic        center;
  logic [15:0] prescale;
  logic [15:0] reload;
  logic        reinit;
  logic        psc_clear;
  logic        cnt_write;
  logic [15:0] cnt_wdata;
  logic [15:0] count;
  logic        wrap;
  logic        tick;

  modport ctrl (output count_en, down, center, prescale, reload, reinit,
                output psc_clear, cnt_write, cnt_wdata,
                input count, wrap, tick);
  modport core (input count_en, down, center, prescale, reload, reinit,
                input psc_clear, cnt_write, cnt_wdata,
                output count, wrap, tick);
endinterface

// [tseg_counter.sv]
// Prescaler and 16-bit counter for the timer.
// Assumes reinit and psc_clear are single-cycle pulses.
`timescale 1ns/1ps
module tseg_counter (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_i,
  // Control side
  tseg_cnt_if.core  cif
);

  logic [15:0] psc_cnt_r;
  logic        going_down_r;

  // ************************************************************
  // Prescaler
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i || cif.psc_clear || cif.reinit) begin
      psc_cnt_r <= 16'h0000;
      cif.tick  <= 1'b0;
    end else if (cif.count_en) begin
      cif.tick  <= (psc_cnt_r == cif.prescale);
      psc_cnt_r <= (psc_cnt_r == cif.prescale) ? 16'h0000 : psc_cnt_r + 16'h0001;
    end else begin
      cif.tick <= 1'b0;
    end
  end

  // ************************************************************
  // Counter
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    cif.wrap <= 1'b0;
    if (reset_i) begin
      cif.count    <= 16'h0000;
      going_down_r <= 1'b0;
    end else if (cif.reinit) begin
      // Down mode restarts from reload, others from zero
      cif.count    <= (cif.down && !cif.center) ? cif.reload : 16'h0000;
      going_down_r <= cif.down && !cif.center;
    end else if (cif.cnt_write) begin
      cif.count <= cif.cnt_wdata;
    end else if (cif.tick) begin
      if (cif.center) begin
        if (!going_down_r && cif.count >= cif.reload) begin
          going_down_r <= 1'b1;
          cif.count    <= cif.count - 16'h0001;
          cif.wrap     <= 1'b1;
        end else if (going_down_r && cif.count == 16'h0000) begin
          going_down_r <= 1'b0;
          cif.count    <= 16'h0001;
          cif.wrap     <= 1'b1;
        end else begin
          cif.count <= going_down_r ? cif.count - 16'h0001 : cif.count + 16'h0001;
        end
      end else if (cif.down) begin
        cif.count <= (cif.count == 16'h0000) ? cif.reload : cif.count - 16'h0001;
        cif.wrap  <= (cif.count == 16'h0000);
      end else begin
        cif.count <= (cif.count >= cif.reload) ? 16'h0000 : cif.count + 16'h0001;
        cif.wrap  <= (cif.count >= cif.reload);
      end
    end
  end

endmodule // tseg_counter

// [tseg_props.sv]
// Port-level checks for the timer status and event block.
// Assumes a bind onto tseg_top; sees its ports only.
`timescale 1ns/1ps
module tseg_props (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        reset_i,
  // Avalon-MM slave
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Timer events
  input wire logic        trigger_reinit_i,
  input wire logic        capture_event_i,
  // Requests
  input wire logic        update_irq_o,
  input wire logic        update_dma_o,
  input wire logic        channel_irq_o,
  input wire logic        channel_dma_o
);
  // ************************************************************
  // Mode shadow, snooped off taken writes
  // ************************************************************
  logic       upd_off_r;
  logic       ch_in_r;
  logic [3:0] en_r;
  logic [5:0] word;
  assign word = avs_address[7:2];
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      upd_off_r <= 1'b0;
      ch_in_r   <= 1'b0;
      en_r      <= 4'h0;
    end else if (avs_write && avs_waitrequest) begin
      // Disable or source select both keep trigger updates off the flag
      if (word == tseg_pkg::OFF_CONTROL[7:2] && avs_byteenable[0])
        upd_off_r <= avs_writedata[1] || avs_writedata[2];
      if (word == tseg_pkg::OFF_ENABLES[7:2] && avs_byteenable[0])
        en_r[1:0] <= avs_writedata[1:0];
      if (word == tseg_pkg::OFF_ENABLES[7:2] && avs_byteenable[1])
        en_r[3:2] <= avs_writedata[9:8];
      if (word == tseg_pkg::OFF_CHMODE[7:2] && avs_byteenable[0])
        ch_in_r <= |avs_writedata[1:0];
    end
  end
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not low after taken request");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without request");
  a_read_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_trig_upd_irq: assert property (trigger_reinit_i && !upd_off_r && en_r[0] |-> ##2 update_irq_o)
    else $error("trigger update gave no update irq");
  a_trig_upd_dma: assert property (trigger_reinit_i && !upd_off_r && en_r[2] |-> ##1 update_dma_o)
    else $error("trigger update gave no update dma");
  a_capture_ch_irq: assert property (capture_event_i && ch_in_r && en_r[1] |-> ##2 channel_irq_o)
    else $error("capture gave no channel irq");
  a_capture_ch_dma: assert property (capture_event_i && ch_in_r && en_r[3] |-> ##1 channel_dma_o)
    else $error("capture gave no channel dma");
  a_upd_irq_gate: assert property (update_irq_o |-> $past(en_r[0]))
    else $error("update irq without enable");
  a_ch_irq_gate: assert property (channel_irq_o |-> $past(en_r[1]))
    else $error("channel irq without enable");
endmodule // tseg_props

// [tb_top.sv]
// Self-checking bench for the timer status and event block.
// Assumes tseg_pkg, tseg_cnt_if, tseg_counter, tseg_top, tseg_props compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("mismatch at %0t got %h exp %h", $time, (got), (exp)); end end
module tb_top;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        trigger_reinit_i = 1'b0;
  logic        capture_event_i = 1'b0;
  logic        update_irq_o, update_dma_o, channel_irq_o, channel_dma_o;
  int          fails = 0;
  int          check_count = 0;
  int          seed = 16169;
  logic [15:0] v, r, md, q;
  always #5 mclk_i = ~mclk_i;
  tseg_top i_tseg_top (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trigger_reinit_i(trigger_reinit_i),
    .capture_event_i(capture_event_i), .update_irq_o(update_irq_o),
    .update_dma_o(update_dma_o), .channel_irq_o(channel_irq_o), .channel_dma_o(channel_dma_o));
  // ************************************************************
  // Bus cycles and expectations
  // ************************************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] be, output logic [15:0] rq);
    avs_address    <= a;
    avs_writedata  <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= !w;
    // Hold everything until waitrequest is seen low
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest !== 1'b0);
    rq = avs_readdata[15:0];
    `CHK(avs_readdata[31:16], 16'h0000)
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] dq;
    bus(1'b1, a, d, 4'hf, dq);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] dq;
    bus(1'b0, a, 16'h0000, 4'hf, dq);
    `CHK(dq, e)
  endtask
  task automatic pulse(input logic trig);
    if (trig) trigger_reinit_i <= 1'b1;
    else capture_event_i <= 1'b1;
    @(posedge mclk_i);
    trigger_reinit_i <= 1'b0;
    capture_event_i  <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask
  function automatic logic [15:0] st(input logic u, input logic c, input logic rep);
    return {6'h00, rep, 7'h00, c, u};
  endfunction
  // Down mode reloads, up and center modes restart at zero
  function automatic logic [15:0] reinit(input logic [15:0] m, input logic [15:0] rl);
    return m[tseg_pkg::CTL_DOWN] ? rl : 16'h0000;
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (5000) @(posedge mclk_i);
    fails++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    rd_chk(tseg_pkg::OFF_STATUS, 16'h0000);
    rd_chk(tseg_pkg::OFF_EVENT, 16'h0000);
    rd_chk(8'h3c, 16'h0000);
    bus(1'b1, tseg_pkg::OFF_ENABLES, 16'h0303, 4'h1, q);
    rd_chk(tseg_pkg::OFF_ENABLES, 16'h0003);
    wr(tseg_pkg::OFF_ENABLES, 16'h0303);
    // Input mode keeps compare hits off the channel flag in update tests
    wr(tseg_pkg::OFF_CHMODE, 16'h0001);
    $display("test reset done");
    for (int m = 0; m < 3; m++) begin
      v = 16'($random(seed));
      r = 16'($random(seed));
      md = (m == 0) ? 16'h0000 : (m == 1) ? 16'h0010 : 16'h0020;
      wr(tseg_pkg::OFF_CONTROL, md);
      wr(tseg_pkg::OFF_PRESCALE, v);
      wr(tseg_pkg::OFF_RELOAD, r);
      wr(tseg_pkg::OFF_COUNTER, v);
      wr(tseg_pkg::OFF_EVENT, 16'h0001);
      rd_chk(tseg_pkg::OFF_COUNTER, reinit(md, r));
      rd_chk(tseg_pkg::OFF_PRESCALE, v);
      rd_chk(tseg_pkg::OFF_EVENT, 16'h0000);
      rd_chk(tseg_pkg::OFF_STATUS, st(1, 0, 0));
      `CHK(update_irq_o, 1'b1)
      wr(tseg_pkg::OFF_STATUS, 16'h0001);
      rd_chk(tseg_pkg::OFF_STATUS, st(1, 0, 0));
      wr(tseg_pkg::OFF_STATUS, 16'hfffe);
      rd_chk(tseg_pkg::OFF_STATUS, st(0, 0, 0));
    end
    $display("test software update done");
    // Update disable, source select one, then both open
    for (int k = 0; k < 3; k++) begin
      md = (k == 0) ? 16'h0002 : (k == 1) ? 16'h0004 : 16'h0000;
      wr(tseg_pkg::OFF_CONTROL, md);
      wr(tseg_pkg::OFF_COUNTER, 16'h00ff);
      pulse(1'b1);
      rd_chk(tseg_pkg::OFF_COUNTER, 16'h0000);
      rd_chk(tseg_pkg::OFF_STATUS, st(k == 2, 0, 0));
      `CHK(update_irq_o, k == 2)
      wr(tseg_pkg::OFF_EVENT, 16'h0001);
      rd_chk(tseg_pkg::OFF_STATUS, st(k == 2, 0, 0));
      wr(tseg_pkg::OFF_STATUS, 16'h0000);
    end
    $display("test update sources done");
    v = {13'h0000, 3'($random(seed))} + 16'h0004;
    wr(tseg_pkg::OFF_CHMODE, 16'h0000);
    wr(tseg_pkg::OFF_PRESCALE, 16'h0000);
    wr(tseg_pkg::OFF_RELOAD, 16'h000f);
    wr(tseg_pkg::OFF_CHANNEL, v);
    wr(tseg_pkg::OFF_COUNTER, 16'h0000);
    wr(tseg_pkg::OFF_STATUS, 16'h0000);
    wr(tseg_pkg::OFF_CONTROL, 16'h0001);
    // Long enough for one compare hit and one wrap at reload 0x0f
    repeat (40) @(posedge mclk_i);
    wr(tseg_pkg::OFF_CONTROL, 16'h0000);
    rd_chk(tseg_pkg::OFF_STATUS, st(1, 1, 0));
    rd_chk(tseg_pkg::OFF_CHANNEL, v);
    rd_chk(tseg_pkg::OFF_STATUS, st(1, 0, 0));
    pulse(1'b0);
    rd_chk(tseg_pkg::OFF_STATUS, st(1, 0, 0));
    wr(tseg_pkg::OFF_EVENT, 16'h0002);
    wr(tseg_pkg::OFF_EVENT, 16'h0002);
    rd_chk(tseg_pkg::OFF_STATUS, st(1, 1, 0));
    `CHK(channel_irq_o, 1'b1)
    rd_chk(tseg_pkg::OFF_EVENT, 16'h0000);
    wr(tseg_pkg::OFF_STATUS, 16'h0000);
    wr(tseg_pkg::OFF_EVENT, 16'hfffc);
    wr(tseg_pkg::OFF_STATUS, 16'hffff);
    rd_chk(tseg_pkg::OFF_STATUS, 16'h0000);
    $display("test output channel done");
    wr(tseg_pkg::OFF_CHMODE, 16'h0001);
    v = 16'($random(seed));
    wr(tseg_pkg::OFF_COUNTER, v);
    pulse(1'b0);
    rd_chk(tseg_pkg::OFF_STATUS, st(0, 1, 0));
    `CHK(channel_irq_o, 1'b1)
    pulse(1'b0);
    rd_chk(tseg_pkg::OFF_STATUS, st(0, 1, 1));
    rd_chk(tseg_pkg::OFF_CHANNEL, v);
    rd_chk(tseg_pkg::OFF_STATUS, st(0, 0, 1));
    wr(tseg_pkg::OFF_STATUS, 16'h0000);
    r = 16'($random(seed));
    wr(tseg_pkg::OFF_COUNTER, r);
    wr(tseg_pkg::OFF_EVENT, 16'h0002);
    rd_chk(tseg_pkg::OFF_STATUS, st(0, 1, 0));
    wr(tseg_pkg::OFF_EVENT, 16'h0002);
    rd_chk(tseg_pkg::OFF_STATUS, st(0, 1, 1));
    rd_chk(tseg_pkg::OFF_CHANNEL, r);
    $display("test input channel done");
    give_verdict();
  end
endmodule // tb_top
bind tseg_top tseg_props i_tseg_props (.mclk_i(mclk_i), .reset_i(reset_i),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .trigger_reinit_i(trigger_reinit_i), .capture_event_i(capture_event_i),
  .update_irq_o(update_irq_o), .update_dma_o(update_dma_o),
  .channel_irq_o(channel_irq_o), .channel_dma_o(channel_dma_o));
